/* src/tsfc_map.svh */
// register offsets, field positions, reset values and architectural constants
`ifndef TSFC_MAP_SVH
`define TSFC_MAP_SVH

`define TSFC_ADDR_W            6
`define TSFC_OFF_CTRL          6'h00
`define TSFC_OFF_TSS_SEL       6'h04
`define TSFC_OFF_TSS_DESC      6'h08
`define TSFC_OFF_LIMITS        6'h0c
`define TSFC_OFF_LDT           6'h10
`define TSFC_OFF_SEG0          6'h14
`define TSFC_OFF_NEW_IP        6'h2c
`define TSFC_OFF_STATUS        6'h30
`define TSFC_OFF_ERR           6'h34
`define TSFC_OFF_TASK          6'h38

`define TSFC_CTRL_START        0
`define TSFC_CTRL_INTERRUPT_RETURN_INSTRUCTION         1
`define TSFC_CTRL_CALL         2
`define TSFC_CTRL_EXT          3
`define TSFC_CTRL_RESUME       4
`define TSFC_CTRL_OVR_EN       5
`define TSFC_CTRL_CPL_LO       8
`define TSFC_CTRL_RST          32'h0000_0000

`define TSFC_DESC_BUSY         16
`define TSFC_DESC_IS32         17
`define TSFC_LDT_VALID         16
`define TSFC_LDT_PRESENT       17
`define TSFC_SEG_READ          16
`define TSFC_SEG_WRITE         17
`define TSFC_SEG_EXEC          18
`define TSFC_SEG_CONF          19
`define TSFC_SEG_DPL_LO        20

`define TSFC_VEC_OVERRUN       8'h09
`define TSFC_VEC_TASK_STATE    8'h0a
`define TSFC_VEC_GEN_PROT      8'h0d
`define TSFC_TSS_MIN32         16'h0067
`define TSFC_TSS_MIN16         16'h002c
`define TSFC_NUM_SEG           6
`define TSFC_SLOT_STACK        3'h0
`define TSFC_SLOT_CODE         3'h1
`define TSFC_SLOT_LAST         3'h5

`endif

/* src/tsfc_pkg.sv */
// types shared by the task-switch check unit
package tsfc_pkg;

   typedef enum logic [1:0] {
      SEG_STACK,
      SEG_CODE,
      SEG_DATA
   } tsfc_seg_kind_t;

   typedef enum {
      ST_IDLE,
      ST_TSS,
      ST_COMMIT,
      ST_LOAD,
      ST_LDT,
      ST_SEG
   } tsfc_state_t;

   typedef struct packed {
      logic        valid;
      logic [7:0]  vector;
      logic        has_err;
      logic [15:0] err_code;
      logic        new_ctx;
      logic [31:0] ip;
   } tsfc_exc_t;

endpackage

/* src/tsfc_err_code.sv */
// error code word: selector index, table indicator, outside-event bit
module tsfc_err_code (
   input  wire logic [15:0] sel_i,
   input  wire logic        ext_i,
   output logic      [15:0] code_o
);
   // the descriptor-table-entry bit stays clear: these faults never name a gate entry
   assign code_o = {sel_i[15:2], 1'b0, ext_i};
endmodule

/* src/tsfc_seg_check.sv */
// validity check of one segment selector loaded from a task state
module tsfc_seg_check (
   input  wire logic                    [15:0] sel_i,
   input  wire logic                    [31:0] attr_i,
   input  wire tsfc_pkg::tsfc_seg_kind_t       kind_i,
   input  wire logic                    [1:0]  cpl_i,
   input  wire logic                    [15:0] gdt_lim_i,
   input  wire logic                    [15:0] ldt_lim_i,
   output logic                                bad_o
);
   `include "tsfc_map.svh"

   logic        over_lim;
   logic [1:0]  descriptor_privilege_level;
   logic [15:0] lim;

   assign lim      = sel_i[2] ? ldt_lim_i : gdt_lim_i;
   assign over_lim = {sel_i[15:3], 3'h7} > lim;
   assign descriptor_privilege_level      = attr_i[`TSFC_SEG_DPL_LO +: 2];

   always_comb begin
      unique case (kind_i)
         tsfc_pkg::SEG_STACK: bad_o = over_lim | ~attr_i[`TSFC_SEG_WRITE]
                                    | (descriptor_privilege_level != cpl_i) | (sel_i[1:0] != cpl_i);
         tsfc_pkg::SEG_CODE:  bad_o = over_lim | ~attr_i[`TSFC_SEG_EXEC]
                                    | (~attr_i[`TSFC_SEG_CONF] & (descriptor_privilege_level != cpl_i))
                                    | (attr_i[`TSFC_SEG_CONF] & (descriptor_privilege_level > cpl_i));
         default:             bad_o = over_lim | ~attr_i[`TSFC_SEG_READ];
      endcase
   end
endmodule

/* src/tsfc_top.sv */
// task-switch state fault check unit with an Avalon-MM register slave
// Functional notes
// - overrun abort optional; else general protection fault
// - overrun abort: no error code, faulting pointer
// - invalid task state raises restartable fault ten
// - task state limit below minimum faults
// - return switch: local-table selector faults
// - return switch: selector beyond table limit faults
// - return switch: inactive target task faults
// - invalid or absent local table faults
// - four stack selector checks fault
// - four code selector checks fault
// - data selector limit or unreadable faults
// - old context before commit, new after
// - commit loads task register; back link too on a call
// - error code carries offending selector index
// - outside event sets error code bit
// - saved pointer: invoking instruction or new task
// - no change before commit; full load after
// - normal switch loads all first; after fault, no checks
// - switch back validates each register on reload
`include "tsfc_map.svh"
module tsfc_top (
   input  wire logic                    clk_i,
   input  wire logic                    rst_b_i,
   input  wire logic                    ce_i,
   input  wire logic [`TSFC_ADDR_W-1:0] avs_address_i,
   input  wire logic                    avs_read_i,
   input  wire logic                    avs_write_i,
   input  wire logic [31:0]             avs_writedata_i,
   input  wire logic [3:0]              avs_byteenable_i,
   output logic      [31:0]             avs_readdata_o,
   output logic                         avs_waitrequest_o,
   input  wire logic                    ovr_event_i,
   input  wire logic [31:0]             cur_ip_i,
   output logic                         ovr_ready_o,
   output tsfc_pkg::tsfc_exc_t          exc_o,
   output logic      [15:0]             task_reg_o,
   output logic      [15:0]             back_link_o,
   output logic      [15:0]             seg_sel_o [`TSFC_NUM_SEG]
);

   localparam int NSEG = `TSFC_NUM_SEG;

   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction

   // bus slave
   logic                  ack_r;
   logic [31:0]           rdata_r;
   logic                  wr_fire;
   logic                  req;

   // configuration
   logic [31:0]           ctrl_r;
   logic [31:0]           tss_sel_r;
   logic [31:0]           tss_desc_r;
   logic [31:0]           limits_r;
   logic [31:0]           ldt_r;
   logic [31:0]           seg_r [NSEG];
   logic [31:0]           new_ip_r;

   // engine state
   tsfc_pkg::tsfc_state_t state_r;
   tsfc_pkg::tsfc_state_t state_nxt;
   logic [2:0]            idx_r;
   logic [NSEG-1:0]       loaded_r;
   logic [NSEG-1:0]       checked_r;
   logic [15:0]           seg_ld_r [NSEG];
   logic [15:0]           tr_r;
   logic [15:0]           link_r;
   logic                  committed_r;
   logic                  done_r;
   logic                  fault_r;
   tsfc_pkg::tsfc_exc_t   exc_r;

   // decisions
   logic                  start;
   logic                  tss_bad;
   logic                  ldt_bad;
   logic [NSEG-1:0]       seg_bad;
   logic                  seg_fault;
   logic                  load_all;
   logic                  load_one;
   logic                  raise;
   logic [15:0]           fault_sel;
   logic [15:0]           fault_code;
   logic [1:0]            current_privilege_level;
   logic                  resume;
   logic                  ovr_take;
   logic [31:0]           task_wr;

   assign current_privilege_level    = ctrl_r[`TSFC_CTRL_CPL_LO +: 2];
   assign resume = ctrl_r[`TSFC_CTRL_RESUME];

   // ---------------- register slave: one wait cycle, answer on the second ----------------
   assign req               = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & ~ack_r;
   assign wr_fire           = avs_write_i & ack_r;
   assign avs_readdata_o    = rdata_r;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ack_r <= 1'b0;
      end else if (ce_i) begin
         ack_r <= req & ~ack_r;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_r <= 32'h0000_0000;
      end else if (ce_i && avs_read_i && !ack_r) begin
         rdata_r <= 32'h0000_0000;
         case (avs_address_i)
            `TSFC_OFF_CTRL:     rdata_r <= {ctrl_r[31:1], 1'b0};
            `TSFC_OFF_TSS_SEL:  rdata_r <= tss_sel_r;
            `TSFC_OFF_TSS_DESC: rdata_r <= tss_desc_r;
            `TSFC_OFF_LIMITS:   rdata_r <= limits_r;
            `TSFC_OFF_LDT:      rdata_r <= ldt_r;
            `TSFC_OFF_NEW_IP:   rdata_r <= new_ip_r;
            `TSFC_OFF_STATUS:   rdata_r <= {exc_r.vector, 8'h00, checked_r, loaded_r,
                                            committed_r, fault_r, done_r,
                                            state_r != tsfc_pkg::ST_IDLE};
            `TSFC_OFF_ERR:      rdata_r <= {16'h0000, exc_r.err_code};
            `TSFC_OFF_TASK:     rdata_r <= {link_r, tr_r};
            default: begin
               for (int i = 0; i < NSEG; i++) begin
                  if (avs_address_i == `TSFC_OFF_SEG0 + 6'(4 * i)) begin
                     rdata_r <= seg_r[i];
                  end
               end
            end
         endcase
      end
   end

   // configuration writes; only the start bit is a strobe, everything else is stored
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_r     <= `TSFC_CTRL_RST;
         tss_sel_r  <= 32'h0000_0000;
         tss_desc_r <= 32'h0000_0000;
         limits_r   <= 32'h0000_0000;
         ldt_r      <= 32'h0000_0000;
         new_ip_r   <= 32'h0000_0000;
      end else if (ce_i && wr_fire) begin
         case (avs_address_i)
            `TSFC_OFF_CTRL:     ctrl_r     <= be_merge(ctrl_r, avs_writedata_i, avs_byteenable_i);
            `TSFC_OFF_TSS_SEL:  tss_sel_r  <= be_merge(tss_sel_r, avs_writedata_i,
                                                       avs_byteenable_i);
            `TSFC_OFF_TSS_DESC: tss_desc_r <= be_merge(tss_desc_r, avs_writedata_i,
                                                       avs_byteenable_i);
            `TSFC_OFF_LIMITS:   limits_r   <= be_merge(limits_r, avs_writedata_i,
                                                       avs_byteenable_i);
            `TSFC_OFF_LDT:      ldt_r      <= be_merge(ldt_r, avs_writedata_i, avs_byteenable_i);
            `TSFC_OFF_NEW_IP:   new_ip_r   <= be_merge(new_ip_r, avs_writedata_i,
                                                       avs_byteenable_i);
            default: ;
         endcase
      end
   end

   // per-slot descriptor registers and checkers; slot 0 stack, slot 1 code, rest data
   generate
      for (genvar g = 0; g < NSEG; g++) begin : g_slot
         tsfc_pkg::tsfc_seg_kind_t kind;

         assign kind = (g == 0) ? tsfc_pkg::SEG_STACK :
                       (g == 1) ? tsfc_pkg::SEG_CODE  : tsfc_pkg::SEG_DATA;

         always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               seg_r[g] <= 32'h0000_0000;
            end else if (ce_i && wr_fire && avs_address_i == `TSFC_OFF_SEG0 + 6'(4 * g)) begin
               seg_r[g] <= be_merge(seg_r[g], avs_writedata_i, avs_byteenable_i);
            end
         end

         tsfc_seg_check u_chk (
            .sel_i     (seg_r[g][15:0]),
            .attr_i    (seg_r[g]),
            .kind_i    (kind),
            .cpl_i     (current_privilege_level),
            .gdt_lim_i (limits_r[15:0]),
            .ldt_lim_i (limits_r[31:16]),
            .bad_o     (seg_bad[g])
         );
      end
   endgenerate

   // ---------------- check engine ----------------
   assign start    = wr_fire && avs_address_i == `TSFC_OFF_CTRL && avs_byteenable_i[0]
                     && avs_writedata_i[`TSFC_CTRL_START] && state_r == tsfc_pkg::ST_IDLE;
   assign ovr_ready_o = state_r == tsfc_pkg::ST_IDLE && !start;
   assign ovr_take    = ovr_event_i && ovr_ready_o;

   always_comb begin
      tss_bad = tss_desc_r[15:0] < (tss_desc_r[`TSFC_DESC_IS32] ? `TSFC_TSS_MIN32
                                                              : `TSFC_TSS_MIN16);
      if (ctrl_r[`TSFC_CTRL_INTERRUPT_RETURN_INSTRUCTION]) begin
         tss_bad = tss_bad | tss_sel_r[2]
                 | ({tss_sel_r[15:3], 3'h7} > limits_r[15:0])
                 | ~tss_desc_r[`TSFC_DESC_BUSY];
      end
   end

   assign ldt_bad   = ~ldt_r[`TSFC_LDT_VALID] | ~ldt_r[`TSFC_LDT_PRESENT];
   assign seg_fault = state_r == tsfc_pkg::ST_SEG && seg_bad[idx_r];

   // the first failing check ends the sequence, later ones are never looked at
   always_comb begin
      raise     = 1'b0;
      fault_sel = 16'h0000;
      state_nxt = state_r;
      unique case (state_r)
         tsfc_pkg::ST_IDLE: begin
            if (start) begin
               state_nxt = tsfc_pkg::ST_TSS;
            end
         end
         tsfc_pkg::ST_TSS: begin
            if (tss_bad) begin
               raise     = 1'b1;
               fault_sel = tss_sel_r[15:0];
               state_nxt = tsfc_pkg::ST_IDLE;
            end else begin
               state_nxt = tsfc_pkg::ST_COMMIT;
            end
         end
         tsfc_pkg::ST_COMMIT: state_nxt = resume ? tsfc_pkg::ST_LDT : tsfc_pkg::ST_LOAD;
         tsfc_pkg::ST_LOAD:   state_nxt = tsfc_pkg::ST_LDT;
         tsfc_pkg::ST_LDT: begin
            if (ldt_bad) begin
               raise     = 1'b1;
               fault_sel = ldt_r[15:0];
               state_nxt = tsfc_pkg::ST_IDLE;
            end else begin
               state_nxt = tsfc_pkg::ST_SEG;
            end
         end
         tsfc_pkg::ST_SEG: begin
            if (seg_fault) begin
               raise     = 1'b1;
               fault_sel = seg_r[idx_r][15:0];
               state_nxt = tsfc_pkg::ST_IDLE;
            end else if (idx_r == `TSFC_SLOT_LAST) begin
               state_nxt = tsfc_pkg::ST_IDLE;
            end
         end
      endcase
   end

   // normal switches load every selector before checking; a switch back loads one at a time
   assign load_all = state_r == tsfc_pkg::ST_LOAD
                     || (raise && state_r != tsfc_pkg::ST_TSS);
   assign load_one = state_r == tsfc_pkg::ST_SEG && resume;

   tsfc_err_code u_err (
      .sel_i  (fault_sel),
      .ext_i  (ctrl_r[`TSFC_CTRL_EXT]),
      .code_o (fault_code)
   );

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r <= tsfc_pkg::ST_IDLE;
         idx_r   <= 3'h0;
      end else if (ce_i) begin
         state_r <= state_nxt;
         if (state_r == tsfc_pkg::ST_SEG) begin
            idx_r <= idx_r + 3'h1;
         end else begin
            idx_r <= `TSFC_SLOT_STACK;
         end
      end
   end

   // segment registers of the running task
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         loaded_r  <= '0;
         checked_r <= '0;
         for (int i = 0; i < NSEG; i++) begin
            seg_ld_r[i] <= 16'h0000;
         end
      end else if (ce_i) begin
         if (start) begin
            loaded_r  <= '0;
            checked_r <= '0;
         end
         if (load_all) begin
            loaded_r <= '1;
            for (int i = 0; i < NSEG; i++) begin
               seg_ld_r[i] <= seg_r[i][15:0];
            end
         end else if (load_one) begin
            loaded_r[idx_r]  <= 1'b1;
            seg_ld_r[idx_r]  <= seg_r[idx_r][15:0];
         end
         if (state_r == tsfc_pkg::ST_SEG && !seg_fault) begin
            checked_r[idx_r] <= 1'b1;
         end
      end
   end

   // back link changes only at the commit point; task register at commit, or by a bus write while idle
   assign task_wr = be_merge({16'h0000, tr_r}, avs_writedata_i, avs_byteenable_i);

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tr_r        <= 16'h0000;
         link_r      <= 16'h0000;
         committed_r <= 1'b0;
      end else if (ce_i) begin
         if (start) begin
            committed_r <= 1'b0;
         end
         if (state_r == tsfc_pkg::ST_COMMIT) begin
            tr_r        <= tss_sel_r[15:0];
            committed_r <= 1'b1;
            if (ctrl_r[`TSFC_CTRL_CALL]) begin
               link_r <= tr_r;
            end
         end else if (wr_fire && avs_address_i == `TSFC_OFF_TASK
                      && state_r == tsfc_pkg::ST_IDLE) begin
            tr_r <= task_wr[15:0];
         end
      end
   end

   // exception report: a one-cycle pulse, fields held until the next report
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         exc_r   <= '0;
         done_r  <= 1'b0;
         fault_r <= 1'b0;
      end else if (ce_i) begin
         exc_r.valid <= 1'b0;
         if (start) begin
            done_r  <= 1'b0;
            fault_r <= 1'b0;
         end
         if (raise) begin
            exc_r.valid    <= 1'b1;
            exc_r.vector   <= `TSFC_VEC_TASK_STATE;
            exc_r.has_err  <= 1'b1;
            exc_r.err_code <= fault_code;
            exc_r.new_ctx  <= state_r != tsfc_pkg::ST_TSS;
            exc_r.ip       <= (state_r == tsfc_pkg::ST_TSS) ? cur_ip_i : new_ip_r;
            fault_r        <= 1'b1;
            done_r         <= 1'b1;
         end else if (state_r == tsfc_pkg::ST_SEG && idx_r == `TSFC_SLOT_LAST) begin
            done_r <= 1'b1;
         end else if (ovr_take) begin
            // the handler cannot resume after an overrun, so only the pointer matters
            exc_r.valid    <= 1'b1;
            exc_r.vector   <= ctrl_r[`TSFC_CTRL_OVR_EN] ? `TSFC_VEC_OVERRUN
                                                        : `TSFC_VEC_GEN_PROT;
            exc_r.has_err  <= !ctrl_r[`TSFC_CTRL_OVR_EN];
            exc_r.err_code <= 16'h0000;
            exc_r.new_ctx  <= 1'b0;
            exc_r.ip       <= cur_ip_i;
         end
      end
   end

   assign exc_o       = exc_r;
   assign task_reg_o  = tr_r;
   assign back_link_o = link_r;
   assign seg_sel_o   = seg_ld_r;

endmodule

/* sim/tsfc_top_props.sv */
// concurrent checks on the ports of the task-switch fault check unit
`include "tsfc_map.svh"
module tsfc_top_props (
   input wire logic                    clk_i,
   input wire logic                    rst_b_i,
   input wire logic                    ce_i,
   input wire logic [`TSFC_ADDR_W-1:0] avs_address_i,
   input wire logic                    avs_read_i,
   input wire logic                    avs_write_i,
   input wire logic [31:0]             avs_readdata_o,
   input wire logic                    avs_waitrequest_o,
   input wire logic                    ovr_event_i,
   input wire logic [31:0]             cur_ip_i,
   input wire logic                    ovr_ready_o,
   input wire tsfc_pkg::tsfc_exc_t     exc_o,
   input wire logic [15:0]             task_reg_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_req_wait;
      (avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i;
   endsequence
   sequence s_ovr_take;
      ovr_event_i && ovr_ready_o && ce_i;
   endsequence
   sequence s_pre_fault;
      exc_o.valid && exc_o.vector == `TSFC_VEC_TASK_STATE && !exc_o.new_ctx;
   endsequence
   chk_wait_one: assert property (s_req_wait |=> !avs_waitrequest_o)
      else $error("access took more than one wait state");
   chk_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o &&
      avs_address_i == 6'h3c |-> avs_readdata_o == 32'h0)
      else $error("unmapped read returned nonzero");
   chk_read_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
      else $error("read data changed without a read");
   chk_ovr_report: assert property (
      s_ovr_take |=> exc_o.valid && exc_o.ip == $past(cur_ip_i) && !exc_o.new_ctx &&
      (exc_o.vector == 8'h09 ? !exc_o.has_err :
       (exc_o.vector == 8'h0d && exc_o.has_err && exc_o.err_code == 16'h0)))
      else $error("overrun report wrong");
   chk_fault_code: assert property (
      exc_o.valid && exc_o.vector == 8'h0a |-> exc_o.has_err && !exc_o.err_code[1])
      else $error("task state fault without proper error code");
   chk_single_report: assert property (exc_o.valid |=> !exc_o.valid)
      else $error("report pulse longer than one cycle");
   chk_pre_ip: assert property (s_pre_fault |-> exc_o.ip == $past(cur_ip_i))
      else $error("pre-commit fault pointer wrong");
   chk_pre_nochange: assert property (
      s_pre_fault |-> $stable(task_reg_o) && task_reg_o == $past(task_reg_o, 3))
      else $error("task register changed before commit");
endmodule

bind tsfc_top tsfc_top_props u_props (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .ovr_event_i(ovr_event_i), .cur_ip_i(cur_ip_i), .ovr_ready_o(ovr_ready_o),
   .exc_o(exc_o), .task_reg_o(task_reg_o));

/* sim/tsfc_top_tb.sv */
// self-checking bench for the task-switch fault check unit
`include "tsfc_map.svh"
module tsfc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                clk_i           = 1'b0;
   logic                rst_b_i         = 1'b0;
   logic [5:0]          avs_address_i   = 6'h00;
   logic                avs_read_i      = 1'b0;
   logic                avs_write_i     = 1'b0;
   logic [31:0]         avs_writedata_i = 32'h0;
   logic                ovr_event_i     = 1'b0;
   logic                ce_i            = 1'b1;
   logic [31:0]         cur_ip_i        = 32'h0000_2000;
   logic [31:0]         avs_readdata_o;
   logic                avs_waitrequest_o;
   logic                ovr_ready_o;
   tsfc_pkg::tsfc_exc_t exc_o;
   logic [15:0]         task_reg_o;
   logic [15:0]         back_link_o;
   logic [15:0]         seg_sel_o [`TSFC_NUM_SEG];
   logic [31:0]         rd;
   int                  err_count  = 0;
   int                  n_compared = 0;

   always #10 clk_i = ~clk_i;

   // invoking pointer stays at 2000 during switches: pre-commit reports must echo it
   tsfc_top DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .ovr_event_i(ovr_event_i),
      .cur_ip_i(cur_ip_i), .ovr_ready_o(ovr_ready_o), .exc_o(exc_o),
      .task_reg_o(task_reg_o), .back_link_o(back_link_o), .seg_sel_o(seg_sel_o));

   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tmo(input logic ok);
      if (ok !== 1'b1) begin
         err_count++;
         report_and_stop();
      end
   endtask

   // one Avalon access; request held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      logic w;
      int   n = 0;
      @(posedge clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      do begin
         @(negedge clk_i);
         w = avs_waitrequest_o;
         rd = avs_readdata_o;
         @(posedge clk_i);
         n++;
      end while (w !== 1'b0 && n < 20);
      tmo(w === 1'b0);
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask

   // a target task that passes every check
   task automatic base();
      bus(1'b1, 6'h04, 32'h0000_0020);
      bus(1'b1, 6'h08, 32'h0003_0067);
      bus(1'b1, 6'h0c, 32'hffff_ffff);
      bus(1'b1, 6'h10, 32'h0003_0030);
      bus(1'b1, 6'h14, 32'h0003_0010);
      bus(1'b1, 6'h18, 32'h0005_0008);
      for (int k = 2; k < 6; k++)
         bus(1'b1, 6'h14 + 6'(4 * k), 32'h0001_0018);
      bus(1'b1, 6'h38, 32'h0000_0040);
   endtask

   task automatic ovr(input logic en);
      int n = 0;
      bus(1'b1, 6'h00, {26'h0, en, 5'h0});
      while (ovr_ready_o !== 1'b1 && n < 20) begin
         @(negedge clk_i);
         n++;
      end
      tmo(ovr_ready_o);
      @(posedge clk_i);
      ovr_event_i <= 1'b1;
      cur_ip_i    <= {28'h0000_300, 3'h0, en};
      @(posedge clk_i);
      ovr_event_i <= 1'b0;
      cur_ip_i    <= 32'h0000_2000;
      @(negedge clk_i);
      check(64'({exc_o.valid, exc_o.vector, exc_o.has_err, exc_o.err_code, exc_o.ip}),
            64'({1'b1, en ? 8'h09 : 8'h0d, ~en, 16'h0, 28'h0000_300, 3'h0, en}));
   endtask

   // one corrupted field (or two), then a switch that must fault on sel
   task automatic sw(input logic [5:0] a1, input logic [31:0] v1, input logic [7:0] ctl,
                     input logic [15:0] sel, input logic post,
                     input logic [5:0] a2 = 6'h2c, input logic [31:0] v2 = 32'h1000);
      int n = 0;
      base();
      bus(1'b1, a1, v1);
      bus(1'b1, a2, v2);
      bus(1'b1, 6'h00, {24'h0, ctl | 8'h01});
      while (exc_o.valid !== 1'b1 && n < 40) begin
         @(negedge clk_i);
         n++;
      end
      tmo(exc_o.valid);
      check(64'({exc_o.vector, exc_o.err_code, exc_o.new_ctx}),
            64'({8'h0a, sel[15:2], 1'b0, ctl[3], post}));
      check(64'(exc_o.ip), post ? 64'h1000 : 64'h2000);
      check(64'(task_reg_o), post ? 64'h0020 : 64'h0040);
      check(64'(seg_sel_o[5]), post ? 64'h0018 : 64'h0);
   endtask

   initial begin
      int n = 0;
      repeat (8) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(negedge clk_i);
      check(64'(exc_o), 64'h0);
      bus(1'b1, 6'h3c, 32'hffff_ffff);
      bus(1'b0, 6'h3c, 32'h0);
      check(64'(rd), 64'h0);
      ovr(1'b1);
      ovr(1'b0);
      sw(6'h08, 32'h0003_0066, 8'h00, 16'h0020, 1'b0);
      sw(6'h08, 32'h0001_002b, 8'h00, 16'h0020, 1'b0);
      sw(6'h04, 32'h0000_0024, 8'h02, 16'h0024, 1'b0);
      sw(6'h0c, 32'hffff_0007, 8'h02, 16'h0020, 1'b0);
      sw(6'h08, 32'h0002_0067, 8'h02, 16'h0020, 1'b0);
      sw(6'h10, 32'h0002_0030, 8'h00, 16'h0030, 1'b1);
      sw(6'h14, 32'h0001_0010, 8'h00, 16'h0010, 1'b1);
      sw(6'h14, 32'h0023_0010, 8'h00, 16'h0010, 1'b1);
      sw(6'h14, 32'h0003_0011, 8'h00, 16'h0011, 1'b1);
      sw(6'h0c, 32'h000f_ffff, 8'h00, 16'h0014, 1'b1, 6'h14, 32'h0003_0014);
      sw(6'h18, 32'h0001_0008, 8'h00, 16'h0008, 1'b1);
      sw(6'h18, 32'h0015_0008, 8'h00, 16'h0008, 1'b1);
      sw(6'h18, 32'h001d_0008, 8'h00, 16'h0008, 1'b1);
      sw(6'h0c, 32'h0007_ffff, 8'h00, 16'h000c, 1'b1, 6'h18, 32'h0005_000c);
      sw(6'h28, 32'h0000_0018, 8'h08, 16'h0018, 1'b1);
      sw(6'h0c, 32'h000f_ffff, 8'h00, 16'h001c, 1'b1, 6'h1c, 32'h0001_001c);
      sw(6'h14, 32'h0001_0010, 8'h00, 16'h0010, 1'b1, 6'h18, 32'h0001_0008);
      // switch back from a handler task: stack slot faults on its check, then every slot is loaded at once
      sw(6'h14, 32'h0001_0010, 8'h10, 16'h0010, 1'b1);
      base();
      bus(1'b1, 6'h00, 32'h0000_0005);
      // a low clock enable must hold the engine before its commit point
      ce_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      check(64'(task_reg_o), 64'h0040);
      ce_i <= 1'b1;
      do begin
         bus(1'b0, 6'h30, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 20);
      tmo(rd[0] === 1'b0);
      check(64'(rd[2:1]), 64'h1);
      check(64'({task_reg_o, back_link_o}), 64'h0020_0040);
      report_and_stop();
   end
endmodule
